// file: hdl/gpp_port.sv
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "gpp_defs.svh"
module gpp_port #(
    parameter gpp_pkg::gpp_variant_type VARIANT = gpp_pkg::GPP_SMALL
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire gpp_pkg::gpp_wb_req_type wb_req_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    input  wire logic [7:0]             port_a_in_i,
    input  wire logic [7:0]             port_b_in_i,
    input  wire logic                   port_c_in_i,
    input  wire logic                   port_d_in_i,
    input  wire logic                   port_e_in_i,
    output gpp_pkg::gpp_pad_type        port_a_pad_o,
    output gpp_pkg::gpp_pad_type        port_b_pad_o,
    output logic                        port_c_dout_o,
    output logic                        port_c_oe_n_o,
    output logic                        port_c_pu_o,
    output logic                        port_d_pu_o,
    output logic                        shared_reset_req_o
);
    localparam logic LARGE = (VARIANT == gpp_pkg::GPP_LARGE);
    localparam logic [7:0] A_OD_M = LARGE ? `GPP_LG_A_OD_MASK : `GPP_SM_A_OD_MASK;
    localparam logic [7:0] B_OD_M = LARGE ? `GPP_LG_B_OD_MASK : `GPP_SM_B_OD_MASK;
    localparam logic [7:0] A_PD_M = LARGE ? `GPP_LG_A_PD_MASK : 8'h00;
    localparam logic [7:0] B_PD_M = LARGE ? `GPP_LG_B_PD_MASK : 8'h00;

    logic [7:0] a_lat_q, a_dir_q, a_pu_q, a_od_q, a_pd_q, a_ana_q;
    logic [7:0] b_lat_q, b_dir_q, b_pu_q, b_od_q, b_pd_q, b_ana_q;
    logic       c_lat_q, c_dir_q, c_pu_q;
    logic       d_pu_q, rstsel_q;
    logic [7:0] a_s1_q, a_s2_q, b_s1_q, b_s2_q;
    logic [2:0] x_s1_q, x_s2_q;
    logic [7:0] rd_d;
    logic       hit;
    logic       wr;

    // two-flop synchronisers for all pin inputs
    always_ff @(posedge clk_i) begin
        a_s1_q <= port_a_in_i;
        a_s2_q <= a_s1_q;
        b_s1_q <= port_b_in_i;
        b_s2_q <= b_s1_q;
        x_s1_q <= {port_e_in_i, port_d_in_i, port_c_in_i};
        x_s2_q <= x_s1_q;
    end

    assign wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & wb_req_i.sel[0] & ~wb_ack_o;

    // port a control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_lat_q <= 8'h00;
            a_dir_q <= `GPP_DIR_RST;
            a_pu_q  <= 8'h00;
            a_od_q  <= 8'h00;
            a_pd_q  <= 8'h00;
            a_ana_q <= `GPP_A_ANA_RST;
        end else if (wr) begin
            if (wb_req_i.adr == `GPP_A_DATA) begin
                a_lat_q <= wb_req_i.dat;
            end else if (wb_req_i.adr == `GPP_A_DIR) begin
                a_dir_q <= wb_req_i.dat;
            end else if (wb_req_i.adr == `GPP_A_PU) begin
                a_pu_q <= wb_req_i.dat;
            end else if (wb_req_i.adr == `GPP_A_OD) begin
                a_od_q <= wb_req_i.dat & A_OD_M;
            end else if (wb_req_i.adr == `GPP_A_PD) begin
                a_pd_q <= wb_req_i.dat & A_PD_M;
            end else if (wb_req_i.adr == `GPP_A_ANA) begin
                a_ana_q <= wb_req_i.dat & `GPP_A_ANA_RST;
            end
        end
    end

    // port b control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            b_lat_q <= 8'h00;
            b_dir_q <= `GPP_DIR_RST;
            b_pu_q  <= 8'h00;
            b_od_q  <= 8'h00;
            b_pd_q  <= 8'h00;
            b_ana_q <= `GPP_B_ANA_RST;
        end else if (wr) begin
            if (wb_req_i.adr == `GPP_B_DATA) begin
                b_lat_q <= wb_req_i.dat & `GPP_B_MASK;
            end else if (wb_req_i.adr == `GPP_B_DIR) begin
                b_dir_q <= wb_req_i.dat | ~`GPP_B_MASK;
            end else if (wb_req_i.adr == `GPP_B_PU) begin
                b_pu_q <= wb_req_i.dat & `GPP_B_MASK;
            end else if (wb_req_i.adr == `GPP_B_OD) begin
                b_od_q <= wb_req_i.dat & B_OD_M;
            end else if (wb_req_i.adr == `GPP_B_PD) begin
                b_pd_q <= wb_req_i.dat & B_PD_M;
            end else if (wb_req_i.adr == `GPP_B_ANA) begin
                b_ana_q <= wb_req_i.dat & `GPP_B_ANA_RST;
            end
        end
    end

    // port c, port d and reset-pin select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c_lat_q  <= 1'b0;
            c_dir_q  <= 1'b1;
            c_pu_q   <= 1'b0;
            d_pu_q   <= 1'b0;
            rstsel_q <= `GPP_RSTSEL_RST;
        end else if (wr) begin
            if (wb_req_i.adr == `GPP_C_DATA) begin
                c_lat_q <= wb_req_i.dat[0];
            end else if (wb_req_i.adr == `GPP_C_DIR) begin
                c_dir_q <= wb_req_i.dat[0];
            end else if (wb_req_i.adr == `GPP_C_PU) begin
                c_pu_q <= wb_req_i.dat[0];
            end else if (wb_req_i.adr == `GPP_D_PU) begin
                d_pu_q <= wb_req_i.dat[0];
            end else if (wb_req_i.adr == `GPP_D_RSTSEL) begin
                rstsel_q <= wb_req_i.dat[0];
            end
        end
    end

    // read mux: pin level in input mode (zero on analog pins), latch in output mode
    always_comb begin
        hit  = 1'b1;
        rd_d = 8'h00;
        if (wb_req_i.adr == `GPP_A_DATA) begin
            rd_d = ((a_dir_q & a_s2_q) | (~a_dir_q & a_lat_q)) & ~(a_ana_q & a_dir_q);
        end else if (wb_req_i.adr == `GPP_A_DIR) begin
            rd_d = a_dir_q;
        end else if (wb_req_i.adr == `GPP_A_PU) begin
            rd_d = a_pu_q;
        end else if (wb_req_i.adr == `GPP_A_OD) begin
            rd_d = a_od_q;
        end else if (wb_req_i.adr == `GPP_A_PD) begin
            rd_d = a_pd_q;
        end else if (wb_req_i.adr == `GPP_A_ANA) begin
            rd_d = a_ana_q;
        end else if (wb_req_i.adr == `GPP_B_DATA) begin
            rd_d = ((b_dir_q & b_s2_q) | (~b_dir_q & b_lat_q)) & ~(b_ana_q & b_dir_q)
                   & `GPP_B_MASK;
        end else if (wb_req_i.adr == `GPP_B_DIR) begin
            rd_d = b_dir_q;
        end else if (wb_req_i.adr == `GPP_B_PU) begin
            rd_d = b_pu_q;
        end else if (wb_req_i.adr == `GPP_B_OD) begin
            rd_d = b_od_q;
        end else if (wb_req_i.adr == `GPP_B_PD) begin
            rd_d = b_pd_q;
        end else if (wb_req_i.adr == `GPP_B_ANA) begin
            rd_d = b_ana_q;
        end else if (wb_req_i.adr == `GPP_C_DATA) begin
            rd_d = {7'h00, c_dir_q ? x_s2_q[0] : c_lat_q};
        end else if (wb_req_i.adr == `GPP_C_DIR) begin
            rd_d = {7'h7f, c_dir_q};
        end else if (wb_req_i.adr == `GPP_C_PU) begin
            rd_d = {7'h00, c_pu_q};
        end else if (wb_req_i.adr == `GPP_D_DATA) begin
            rd_d = 8'h00;
            rd_d[`GPP_D_BIT] = rstsel_q | x_s2_q[1]; // reset mode reads one
        end else if (wb_req_i.adr == `GPP_D_PU) begin
            rd_d = {7'h00, d_pu_q};
        end else if (wb_req_i.adr == `GPP_D_RSTSEL) begin
            rd_d = {7'h00, rstsel_q};
        end else if (wb_req_i.adr == `GPP_E_DATA) begin
            rd_d = 8'h00;
            rd_d[`GPP_E_BIT] = x_s2_q[2];
        end else begin
            hit = 1'b0;
        end
    end

    // wishbone answer: one-cycle ack, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
            wb_dat_o <= {24'h000000, hit ? rd_d : 8'h00};
        end
    end

    // pad drive: dir 0 enables output buffer
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pad
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    port_a_pad_o.dout[i] <= 1'b0;
                    port_a_pad_o.oe_n[i] <= 1'b1;
                    port_a_pad_o.pu[i]   <= 1'b0;
                    port_a_pad_o.pd[i]   <= 1'b0;
                    port_b_pad_o.dout[i] <= 1'b0;
                    port_b_pad_o.oe_n[i] <= 1'b1;
                    port_b_pad_o.pu[i]   <= 1'b0;
                    port_b_pad_o.pd[i]   <= 1'b0;
                end else begin
                    port_a_pad_o.dout[i] <= a_lat_q[i];
                    // open-drain drives only the active level, p-channel drives high
                    if (a_dir_q[i]) begin
                        port_a_pad_o.oe_n[i] <= 1'b1;
                    end else if (a_od_q[i] && LARGE && A_PD_M[i] == 1'b0) begin
                        port_a_pad_o.oe_n[i] <= ~a_lat_q[i];
                    end else if (a_od_q[i]) begin
                        port_a_pad_o.oe_n[i] <= a_lat_q[i];
                    end else begin
                        port_a_pad_o.oe_n[i] <= 1'b0;
                    end
                    port_a_pad_o.pu[i] <= a_dir_q[i] & a_pu_q[i] & ~a_ana_q[i];
                    port_a_pad_o.pd[i] <= a_dir_q[i] & a_pd_q[i] & ~a_ana_q[i];
                    port_b_pad_o.dout[i] <= b_lat_q[i];
                    if (b_dir_q[i]) begin
                        port_b_pad_o.oe_n[i] <= 1'b1;
                    end else if (b_od_q[i]) begin
                        port_b_pad_o.oe_n[i] <= b_lat_q[i];
                    end else begin
                        port_b_pad_o.oe_n[i] <= 1'b0;
                    end
                    port_b_pad_o.pu[i] <= b_dir_q[i] & b_pu_q[i] & ~b_ana_q[i];
                    port_b_pad_o.pd[i] <= b_dir_q[i] & b_pd_q[i] & ~b_ana_q[i];
                end
            end
        end
    endgenerate

    // port c pad, port d pull-up and reset request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_c_dout_o      <= 1'b0;
            port_c_oe_n_o      <= 1'b1;
            port_c_pu_o        <= 1'b0;
            port_d_pu_o        <= 1'b1;
            shared_reset_req_o <= 1'b0;
        end else begin
            port_c_dout_o      <= c_lat_q;
            port_c_oe_n_o      <= c_dir_q;
            port_c_pu_o        <= c_dir_q & c_pu_q;
            port_d_pu_o        <= rstsel_q | d_pu_q;
            shared_reset_req_o <= rstsel_q & ~x_s2_q[1];
        end
    end
endmodule

// file: hdl/gpp_defs.svh
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH

// register word offsets (byte addresses)
`define GPP_A_DATA        8'h00
`define GPP_A_DIR         8'h04
`define GPP_A_PU          8'h08
`define GPP_A_OD          8'h0c
`define GPP_A_PD          8'h10
`define GPP_A_ANA         8'h14
`define GPP_B_DATA        8'h20
`define GPP_B_DIR         8'h24
`define GPP_B_PU          8'h28
`define GPP_B_OD          8'h2c
`define GPP_B_PD          8'h30
`define GPP_B_ANA         8'h34
`define GPP_C_DATA        8'h40
`define GPP_C_DIR         8'h44
`define GPP_C_PU          8'h48
`define GPP_D_DATA        8'h50
`define GPP_D_PU          8'h54
`define GPP_D_RSTSEL      8'h58
`define GPP_E_DATA        8'h60
// reset values
`define GPP_DIR_RST       8'hff
`define GPP_A_ANA_RST     8'h80
`define GPP_B_ANA_RST     8'h7f
`define GPP_RSTSEL_RST    1'h1
// implemented bit masks and bit positions
`define GPP_B_MASK        8'h7f
`define GPP_SM_A_OD_MASK  8'h40
`define GPP_SM_B_OD_MASK  8'h01
`define GPP_LG_A_OD_MASK  8'hff
`define GPP_LG_B_OD_MASK  8'h3f
`define GPP_LG_A_PD_MASK  8'hc0
`define GPP_LG_B_PD_MASK  8'h3f
`define GPP_A_PCH_MASK    8'h3f
`define GPP_D_BIT         5
`define GPP_E_BIT         7
`endif

// file: hdl/gpp_pkg.sv
package gpp_pkg;
    // wishbone request from master
    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [7:0] dat;
    } gpp_wb_req_type;
    // per-port pad control
    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe_n;
        logic [7:0] pu;
        logic [7:0] pd;
    } gpp_pad_type;
    // product variant
    typedef enum logic [1:0] {
        GPP_SMALL = 2'b01,
        GPP_LARGE = 2'b10
    } gpp_variant_type;
endpackage

// file: verification/gpp_board.sv
`timescale 1ns/1ps
module gpp_board (
    input  wire logic                 clk_i,
    input  wire gpp_pkg::gpp_pad_type a_pad_i,
    input  wire gpp_pkg::gpp_pad_type b_pad_i,
    input  wire logic                 c_dout_i,
    input  wire logic                 c_oe_n_i,
    input  wire logic                 c_pu_i,
    input  wire logic [7:0]           a_ext_en_i,
    input  wire logic [7:0]           a_ext_i,
    input  wire logic                 d_low_i,
    output logic [7:0]                a_pin_o,
    output logic [7:0]                b_pin_o,
    output logic                      c_pin_o,
    output logic                      d_pin_o
);
    logic [16:0] last_q = '0;
    // pad level: own drive, board drive, pull, else drifting
    function automatic logic lvl(input logic oe_n, dout, en, ext, pu, pd, last);
        if (!oe_n) return dout;
        if (en) return ext;
        if (pu) return 1'b1;
        if (pd) return 1'b0;
        return ~last;
    endfunction
    // resolve pins a, b and c from pad drive and pulls, pin a also from the board; pin d from the board only
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            a_pin_o[i] = lvl(a_pad_i.oe_n[i], a_pad_i.dout[i], a_ext_en_i[i], a_ext_i[i],
                             a_pad_i.pu[i], a_pad_i.pd[i], last_q[i]);
            b_pin_o[i] = lvl(b_pad_i.oe_n[i], b_pad_i.dout[i], 1'b0, 1'b0,
                             b_pad_i.pu[i], b_pad_i.pd[i], last_q[8+i]);
        end
        c_pin_o = lvl(c_oe_n_i, c_dout_i, 1'b0, 1'b0, c_pu_i, 1'b0, last_q[16]);
        d_pin_o = !d_low_i;
    end
    // remember levels so a floating pin keeps moving
    always @(posedge clk_i) last_q <= {c_pin_o, b_pin_o, a_pin_o};
endmodule

// file: verification/gpp_port_chk.sv
`timescale 1ns/1ps
module gpp_port_chk #(
    parameter gpp_pkg::gpp_variant_type VARIANT = gpp_pkg::GPP_SMALL
) (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire gpp_pkg::gpp_wb_req_type wb_req_i,
    input wire logic [31:0]             wb_dat_o,
    input wire logic                    wb_ack_o,
    input wire logic                    port_d_in_i,
    input wire gpp_pkg::gpp_pad_type    port_a_pad_o,
    input wire gpp_pkg::gpp_pad_type    port_b_pad_o,
    input wire logic                    port_c_oe_n_o,
    input wire logic                    port_c_pu_o,
    input wire logic                    port_d_pu_o,
    input wire logic                    shared_reset_req_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // bus answer timing
    chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_next_cycle: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    chk_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    // pads after reset
    chk_reset_pads: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> port_a_pad_o.oe_n == 8'hff && port_b_pad_o.oe_n == 8'hff
        && port_c_oe_n_o && port_d_pu_o) else $error("pads not idle after reset");
    // pulls only on non-driven pins, no pull-down in small variant, reset pin pull-up and request
    chk_a_pull_input: assert property (((port_a_pad_o.pu | port_a_pad_o.pd)
        & ~port_a_pad_o.oe_n) == 8'h00) else $error("port a pull on driven pin");
    chk_b_pull_input: assert property (((port_b_pad_o.pu | port_b_pad_o.pd)
        & ~port_b_pad_o.oe_n) == 8'h00 && port_b_pad_o.oe_n[7])
        else $error("port b pull on driven pin");
    chk_c_pull_input: assert property (port_c_pu_o |-> port_c_oe_n_o)
        else $error("port c pull while driving");
    chk_small_no_pd: assert property (VARIANT == gpp_pkg::GPP_SMALL |->
        (port_a_pad_o.pd | port_b_pad_o.pd) == 8'h00) else $error("pull-down in small variant");
    chk_d_reset_pull: assert property (shared_reset_req_o |-> port_d_pu_o)
        else $error("reset pin without pull-up");
    chk_high_no_req: assert property (port_d_in_i [*4] |-> !shared_reset_req_o)
        else $error("reset request with pin high");
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam gpp_pkg::gpp_variant_type VARIANT = gpp_pkg::GPP_LARGE;
    logic                    clk_i = 1'b0;
    logic                    rst_i = 1'b1;
    gpp_pkg::gpp_wb_req_type wb_req = '0;
    gpp_pkg::gpp_pad_type    pad_a, pad_b, sm_a, sm_b;
    logic [31:0]             wb_dat, rd;
    logic [7:0]              pin_a, pin_b, a_ext_en = 8'h00, a_ext = 8'h00;
    logic                    wb_ack, pin_c, pin_d, c_dout, c_oe_n, c_pu, d_pu, rst_req;
    logic                    d_low = 1'b0, pin_e = 1'b1;
    logic [7:0]              rst_adr [7] = '{8'h04, 8'h24, 8'h44, 8'h14, 8'h34, 8'h58, 8'hfc};
    logic [7:0]              rst_val [7] = '{8'hff, 8'hff, 8'hff, 8'h80, 8'h7f, 8'h01, 8'h00};
    int                      n_mismatch = 0, comparisons = 0, cycles = 0;
    // 50 ns clock
    always #25 clk_i = ~clk_i;
    gpp_port #(.VARIANT(VARIANT)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
        .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .port_a_in_i(pin_a), .port_b_in_i(pin_b),
        .port_c_in_i(pin_c), .port_d_in_i(pin_d), .port_e_in_i(pin_e), .port_a_pad_o(pad_a),
        .port_b_pad_o(pad_b), .port_c_dout_o(c_dout), .port_c_oe_n_o(c_oe_n),
        .port_c_pu_o(c_pu), .port_d_pu_o(d_pu), .shared_reset_req_o(rst_req));
    gpp_board board_u (.clk_i(clk_i), .a_pad_i(pad_a), .b_pad_i(pad_b), .c_dout_i(c_dout),
        .c_oe_n_i(c_oe_n), .c_pu_i(c_pu), .a_ext_en_i(a_ext_en), .a_ext_i(a_ext),
        .d_low_i(d_low), .a_pin_o(pin_a), .b_pin_o(pin_b), .c_pin_o(pin_c), .d_pin_o(pin_d));
    // small variant twin on the same bus, for its open-drain masks
    gpp_port #(.VARIANT(gpp_pkg::GPP_SMALL)) sm_u (.clk_i(clk_i), .rst_i(rst_i),
        .wb_req_i(wb_req), .wb_dat_o(), .wb_ack_o(), .port_a_in_i(pin_a), .port_b_in_i(pin_b),
        .port_c_in_i(pin_c), .port_d_in_i(pin_d), .port_e_in_i(pin_e), .port_a_pad_o(sm_a),
        .port_b_pad_o(sm_b), .port_c_dout_o(), .port_c_oe_n_o(), .port_c_pu_o(),
        .port_d_pu_o(), .shared_reset_req_o());
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic wishbone cycle, held until ack
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: dat};
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        rd = wb_dat;
        wb_req <= '0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        bus(1'b1, adr, dat);
    endtask
    task automatic rdc(input logic [7:0] adr, input logic [7:0] exp);
        bus(1'b0, adr, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    task automatic settle;
        repeat (4) @(posedge clk_i);
    endtask
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            test_done();
        end
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(pad_a.oe_n, 8'hff);
        for (int i = 0; i < 7; i++) rdc(rst_adr[i], rst_val[i]);
        chk(d_pu, 1'b1);
        wr(8'h14, 8'h00);
        wr(8'h04, 8'h0f);
        wr(8'h00, 8'ha5);
        a_ext_en <= 8'h0f;
        a_ext <= 8'h06;
        settle();
        chk(pad_a.oe_n, 8'h0f);
        chk(pad_a.dout[7:4], 4'ha);
        rdc(8'h00, 8'ha6);
        wr(8'h08, 8'h3f);
        wr(8'h10, 8'hff);
        settle();
        chk({pad_a.pu, pad_a.pd}, 16'h0f00);
        a_ext_en <= 8'h00;
        wr(8'h04, 8'hff);
        settle();
        chk({pad_a.pu, pad_a.pd}, 16'h3fc0);
        rdc(8'h00, 8'h3f);
        wr(8'h08, 8'h00);
        wr(8'h10, 8'h00);
        wr(8'h0c, 8'hff);
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h41);
        settle();
        chk(pad_a.oe_n, 8'h7e);
        chk(sm_a.oe_n, 8'h40);
        wr(8'h34, 8'h00);
        wr(8'h2c, 8'h3f);
        wr(8'h28, 8'h40);
        wr(8'h30, 8'h3f);
        wr(8'h24, 8'h40);
        wr(8'h20, 8'h15);
        settle();
        chk(pad_b.oe_n, 8'hd5);
        chk(sm_b.oe_n, 8'hc1);
        chk(pad_b.dout, 8'h15);
        chk({pad_b.pu, pad_b.pd}, 16'h4000);
        wr(8'h24, 8'h7f);
        settle();
        chk({pad_b.pu, pad_b.pd}, 16'h403f);
        rdc(8'h20, 8'h40);
        wr(8'h44, 8'h00);
        wr(8'h40, 8'h01);
        settle();
        chk({c_oe_n, c_dout}, 2'b01);
        wr(8'h44, 8'h01);
        wr(8'h48, 8'h01);
        settle();
        chk(c_pu, 1'b1);
        rdc(8'h40, 8'h01);
        d_low <= 1'b1;
        settle();
        chk({d_pu, rst_req}, 2'b11);
        rdc(8'h50, 8'h20);
        wr(8'h58, 8'h00);
        settle();
        chk({d_pu, rst_req}, 2'b00);
        wr(8'h54, 8'h01);
        settle();
        chk(d_pu, 1'b1);
        rdc(8'h50, 8'h00);
        d_low <= 1'b0;
        pin_e <= 1'b0;
        settle();
        rdc(8'h60, 8'h00);
        pin_e <= 1'b1;
        settle();
        rdc(8'h60, 8'h80);
        test_done();
    end
endmodule
bind gpp_port gpp_port_chk #(.VARIANT(VARIANT)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_d_in_i(port_d_in_i),
    .port_a_pad_o(port_a_pad_o), .port_b_pad_o(port_b_pad_o), .port_c_oe_n_o(port_c_oe_n_o),
    .port_c_pu_o(port_c_pu_o), .port_d_pu_o(port_d_pu_o),
    .shared_reset_req_o(shared_reset_req_o));
